// ===== include/irq_fm_pkg.sv
package irq_fm_pkg;

   localparam logic [7:0] CMD_MASK_SET_RD = 8'h04;
   localparam logic [7:0] CMD_MASK_SET_WR = 8'h84;
   localparam logic [7:0] CMD_MASK_CLR_RD = 8'h05;
   localparam logic [7:0] CMD_MASK_CLR_WR = 8'h85;
   localparam logic [7:0] CMD_SPACING_RD = 8'h0D;
   localparam logic [7:0] CMD_SPACING_WR = 8'h8D;
   localparam logic [7:0] CMD_FLAGS_RD = 8'h03;
   localparam logic [7:0] CMD_FLAGS_WR = 8'h83;

   localparam logic [31:0] MASK_BITS = 32'h8000_007D;
   localparam logic [31:0] FLAG_BITS = 32'h0000_007D;
   localparam logic [31:0] SPACING_BITS = 32'hFFFF_3FFF;
   localparam int MIE_POS = 31;
   localparam int TOGGLE_POS = 31;
   localparam int BUDGET_LSB = 16;
   localparam int BUDGET_W = 15;
   localparam int SPACING_W = 14;
   localparam logic [13:0] SPACING_NOMINAL = 14'h2EDF;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] SPACING_RESET = {18'h0_0000, SPACING_NOMINAL};

   typedef struct packed {
      logic toggle;
      logic [14:0] budget;
      logic [13:0] spacing;
   } frame_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

endpackage

// ===== rtl/irq_mask_unit.sv
`timescale 1ns/1ps
`default_nettype none
module irq_mask_unit (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic soft_rst,
   input wire logic set_we,
   input wire logic clr_we,
   input wire logic [31:0] wdata,
   input wire logic [31:0] flags,
   output logic [31:0] mask_q,
   output logic irq
);
   logic [31:0] mask_d;

   always_comb begin
      mask_d = mask_q;
      if (set_we) begin
         mask_d = mask_q | (wdata & irq_fm_pkg::MASK_BITS); // R16
      end
      if (clr_we) begin
         mask_d = mask_q & ~(wdata & irq_fm_pkg::MASK_BITS); // R1 R2 R5 R7 R8
      end
   end

   // Master enable starts cleared on either reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= irq_fm_pkg::MASK_RESET; // R6
      end else if (clk_en) begin
         if (soft_rst) begin
            mask_q <= irq_fm_pkg::MASK_RESET; // R6
         end else begin
            mask_q <= mask_d;
         end
      end
   end

   assign irq = mask_q[irq_fm_pkg::MIE_POS] &
                (|(flags & mask_q & irq_fm_pkg::FLAG_BITS)); // R15
endmodule
`default_nettype wire

// ===== rtl/frame_spacing_reg.sv
`timescale 1ns/1ps
`default_nettype none
module frame_spacing_reg (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic soft_rst,
   input wire logic we,
   input wire logic [31:0] wdata,
   output irq_fm_pkg::frame_cfg_t cfg_q
);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q.toggle <= 1'b0;
         cfg_q.budget <= 15'h0000; // R10
         cfg_q.spacing <= irq_fm_pkg::SPACING_NOMINAL; // R14
      end else if (clk_en) begin
         if (soft_rst) begin
            // Only the spacing is restored; budget and toggle stay
            cfg_q.spacing <= irq_fm_pkg::SPACING_NOMINAL; // R14
         end else if (we) begin
            cfg_q.toggle <= wdata[irq_fm_pkg::TOGGLE_POS]; // R13
            cfg_q.budget <= wdata[irq_fm_pkg::BUDGET_LSB +: irq_fm_pkg::BUDGET_W]; // R10
            cfg_q.spacing <= wdata[irq_fm_pkg::SPACING_W-1:0]; // R9 R11
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/usb_host_irq_frame_regs.sv
// How it works
// R1 - Writing one to a disable bit clears that interrupt mask bit.
// R2 - Disable bits written zero leave the mask unchanged.
// R3 - Reading the disable register returns the current interrupt mask.
// R4 - Disable register read with code 05h, written with code 85h.
// R5 - Bit 31 one turns off master interrupt; zero does nothing.
// R6 - Master interrupt is disabled after hardware or software reset.
// R7 - Bits 6, 5, 4 mask hub change, frame overflow, fatal error.
// R8 - Bits 3, 2, 0 mask resume, frame start, overrun; bit 1 reserved.
// R9 - Frame spacing bits 13:0 hold bit times between frame starts.
// R10 - Bits 30:16 hold the largest packet budget, reset zero.
// R11 - Driver may rewrite spacing every frame; new value used later.
// R12 - Frame spacing read with code 0Dh, written with code 8Dh.
// R13 - Driver flips bit 31 toggle whenever it loads new spacing.
// R14 - Controller soft reset restores spacing to 11999 bit times.
// R15 - Interrupt only when flag set, its mask set and master set.
// R16 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module usb_host_irq_frame_regs (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic controller_soft_reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [6:0] event_pulse,
   output logic irq,
   output logic [13:0] frame_spacing_bits,
   output logic [14:0] largest_packet_budget,
   output logic interval_toggle
);
   irq_fm_pkg::bus_req_t req;
   irq_fm_pkg::frame_cfg_t cfg;
   logic [31:0] mask;
   logic [31:0] flags_q;
   logic [31:0] flags_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic mask_set_we;
   logic mask_clr_we;
   logic spacing_we;
   logic flags_clr_we;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] code);
      hit = (a == code);
   endfunction

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   assign mask_set_we = req.wr && hit(req.addr, irq_fm_pkg::CMD_MASK_SET_WR);
   assign mask_clr_we = req.wr && hit(req.addr, irq_fm_pkg::CMD_MASK_CLR_WR); // R4
   assign spacing_we = req.wr && hit(req.addr, irq_fm_pkg::CMD_SPACING_WR); // R12
   assign flags_clr_we = req.wr && hit(req.addr, irq_fm_pkg::CMD_FLAGS_WR);

   irq_mask_unit u_mask (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .soft_rst(controller_soft_reset),
      .set_we(mask_set_we),
      .clr_we(mask_clr_we),
      .wdata(req.wdata),
      .flags(flags_q),
      .mask_q(mask),
      .irq(irq)
   );

   frame_spacing_reg u_spacing (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .soft_rst(controller_soft_reset),
      .we(spacing_we),
      .wdata(req.wdata),
      .cfg_q(cfg)
   );

   // Set beats write-one-to-clear so a coincident event survives
   always_comb begin
      flags_d = flags_q;
      if (flags_clr_we) begin
         flags_d = flags_d & ~(req.wdata & irq_fm_pkg::FLAG_BITS);
      end
      flags_d = flags_d | ({25'h000_0000, event_pulse} & irq_fm_pkg::FLAG_BITS); // R16
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (controller_soft_reset) begin
            flags_q <= 32'h0000_0000;
         end else begin
            flags_q <= flags_d;
         end
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (req.rd) begin
         case (req.addr)
            irq_fm_pkg::CMD_MASK_SET_RD: rdata_d = mask;
            irq_fm_pkg::CMD_MASK_CLR_RD: rdata_d = mask; // R3 R4
            irq_fm_pkg::CMD_SPACING_RD: rdata_d = {cfg.toggle, cfg.budget, 2'b00, cfg.spacing} &
                                                  irq_fm_pkg::SPACING_BITS; // R12 R16
            irq_fm_pkg::CMD_FLAGS_RD: rdata_d = flags_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
   assign frame_spacing_bits = cfg.spacing; // R9 R11
   assign largest_packet_budget = cfg.budget; // R10
   assign interval_toggle = cfg.toggle; // R13
endmodule
`default_nettype wire

// ===== verification/host_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_driver_model (
   input wire logic sys_clk,
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd
);
   initial begin
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One strobe cycle, then an idle cycle with the address scrambled
   task automatic put(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge sys_clk);
      addr <= ~a;
      wdata <= ~d;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verification/usb_host_irq_frame_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_irq_frame_regs_chk (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic controller_soft_reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [6:0] event_pulse,
   input wire logic irq,
   input wire logic [13:0] frame_spacing_bits,
   input wire logic [14:0] largest_packet_budget,
   input wire logic interval_toggle
);
   logic go;
   assign go = clk_en && !controller_soft_reset;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_clear_drops_mask: assert property (wr && go && addr == 8'h85 ##1 !wr ##1 rd && go &&
      addr == 8'h05 |=> (rdata & $past(wdata, 3) & irq_fm_pkg::MASK_BITS) == 32'h0000_0000)
      else $error("mask bit survived disable");
   a_set_reads_back: assert property (wr && go && addr == 8'h84 ##1 !wr ##1 rd && go &&
      addr == 8'h05 |=> (rdata & $past(wdata, 3)) == ($past(wdata, 3) & irq_fm_pkg::MASK_BITS))
      else $error("disable read lost mask");
   a_master_off_quiet: assert property (wr && go && addr == 8'h85 && wdata[31] |=> !irq)
      else $error("irq with master off");
   a_soft_reset_state: assert property (clk_en && controller_soft_reset |=> !irq &&
      frame_spacing_bits == irq_fm_pkg::SPACING_NOMINAL) else $error("soft reset state");
   a_spacing_write: assert property (wr && go && addr == 8'h8D |=>
      {interval_toggle, largest_packet_budget, 2'b00, frame_spacing_bits} ==
      ($past(wdata) & irq_fm_pkg::SPACING_BITS)) else $error("spacing write");
   a_spacing_read: assert property (rd && go && addr == 8'h0D |=> rdata ==
      {interval_toggle, largest_packet_budget, 2'b00, frame_spacing_bits})
      else $error("spacing read");
   a_idle_rdata_zero: assert property (clk_en && !rd |=> rdata == 32'h0000_0000)
      else $error("rdata not idle");
   a_irq_has_cause: assert property (!irq && event_pulse == 7'h00 &&
      !(wr && addr == 8'h84) |=> !irq) else $error("irq without cause");
   a_spacing_holds: assert property (go && !(wr && addr == 8'h8D) |=>
      $stable(frame_spacing_bits)) else $error("spacing moved");
endmodule
bind usb_host_irq_frame_regs usb_host_irq_frame_regs_chk u_chk (.*);
`default_nettype wire

// ===== verification/test_usb_host_irq_frame_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_host_irq_frame_regs;
   logic sys_clk, arst_n, clk_en, controller_soft_reset, wr, rd, irq, interval_toggle;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [6:0] event_pulse;
   logic [13:0] frame_spacing_bits;
   logic [14:0] largest_packet_budget;
   int failures = 0, samples_checked = 0, cyc = 0;
   host_driver_model u_host (.*);
   usb_host_irq_frame_regs u_dut (.*);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      u_host.put(a, 32'h0000_0000, 1'b0);
      #1 chk(rdata, exp);
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      controller_soft_reset = 1'b0;
      event_pulse = 7'h00;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      rdc(8'h0D, 32'h0000_2EDF);
      rdc(8'h05, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         u_host.put(8'h84, 32'hFFFF_FFFF, 1'b1);
         u_host.put(8'h85, 32'h0000_0001 << i, 1'b1);
         rdc(8'h05, 32'h8000_007D & ~(32'h0000_0001 << i));
      end
      @(posedge sys_clk) event_pulse <= 7'h04;
      @(posedge sys_clk) event_pulse <= 7'h00;
      #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
      u_host.put(8'h85, 32'h8000_0000, 1'b1);
      #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
      u_host.put(8'h84, 32'h0000_0004, 1'b1);
      #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
      u_host.put(8'h84, 32'h8000_0000, 1'b1);
      #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
      rdc(8'h05, 32'h8000_003D);
      u_host.put(8'h8D, 32'hFFFF_FFFF, 1'b1);
      rdc(8'h0D, 32'hFFFF_3FFF);
      u_host.put(8'h8D, 32'h0001_2EE0, 1'b1);
      #1 chk({interval_toggle, largest_packet_budget, 2'b00, frame_spacing_bits},
         32'h0001_2EE0);
      @(posedge sys_clk) controller_soft_reset <= 1'b1;
      @(posedge sys_clk) controller_soft_reset <= 1'b0;
      #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
      rdc(8'h0D, 32'h0001_2EDF);
      rdc(8'h05, 32'h0000_0000);
      @(posedge sys_clk) event_pulse <= 7'h7F;
      @(posedge sys_clk) event_pulse <= 7'h00;
      rdc(8'h03, 32'h0000_007D);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      u_host.put(8'h84, 32'h8000_0001, 1'b1);
      #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
      u_host.put(8'h83, 32'hFFFF_FFFF, 1'b1);
      #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
      u_host.put(8'h84, 32'h0000_0004, 1'b1);
      // Frozen cycle must swallow the clear
      @(posedge sys_clk) clk_en <= 1'b0;
      u_host.put(8'h85, 32'hFFFF_FFFF, 1'b1);
      clk_en <= 1'b1;
      rdc(8'h05, 32'h8000_0005);
      u_host.put(8'h8E, 32'hFFFF_FFFF, 1'b1);
      rdc(8'h0E, 32'h0000_0000);
      print_verdict();
   end
endmodule
`default_nettype wire
